// ### rtl/pfb_map.svh
// Register map, field positions and reset values of the blanking block
`ifndef PFB_MAP_SVH
`define PFB_MAP_SVH

`define PFB_ADDR_W        4
`define PFB_OFS_CTRL      4'h0
`define PFB_OFS_COUNT     4'h1
`define PFB_OFS_STATUS    4'h2

`define PFB_CTRL_RESET    16'h0000
`define PFB_CTRL_MASK     16'hFC3F
`define PFB_COUNT_RESET   16'h000A
`define PFB_CNT_ZERO      16'h0000
`define PFB_CNT_ONE       16'h0001

`define PFB_BIT_HRISE     15
`define PFB_BIT_HFALL     14
`define PFB_BIT_LRISE     13
`define PFB_BIT_LFALL     12
`define PFB_BIT_FLTLE     11
`define PFB_BIT_CLLE      10
`define PFB_BIT_SIGH      5
`define PFB_BIT_SIGL      4
`define PFB_BIT_HH        3
`define PFB_BIT_HL        2
`define PFB_BIT_LH        1
`define PFB_BIT_LL        0

`endif

// ### rtl/pfb_pkg.sv
// Types shared by the blanking block
package pfb_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } pfb_bus_t;

  typedef struct packed {
    logic high_side_output;
    logic low_side_output;
    logic blank_sig;
  } pfb_pwm_t;

  typedef struct packed {
    logic fault;
    logic curlim;
  } pfb_flt_t;

endpackage

// ### rtl/pfb_blank.sv
// Fault and current-limit blanking for one PWM channel
// Notes on behaviour
// - High-side rising edge starts edge blanking when its enable is set.
// - High-side falling edge starts edge blanking when its enable is set.
// - Low-side rising edge starts edge blanking when its enable is set.
// - Low-side falling edge starts edge blanking when its enable is set.
// - Edges with a cleared enable never start or restart blanking.
// - Fault masked during edge blanking only when its enable is set.
// - Current limit masked during edge blanking only when enabled.
// - State blanking masks both inputs while any enabled condition holds.
// - Blanking signal high blanks when its enable is set.
// - Blanking signal low blanks when its enable is set.
// - High-side output high blanks when its enable is set.
// - High-side output low blanks when its enable is set.
// - Low-side output high blanks when its enable is set.
// - Low-side output low blanks when its enable is set.
`timescale 1ns/1ps
`default_nettype none
`include "pfb_map.svh"

module pfb_blank
(
  // Clock, reset, enable
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire logic           ce,
  // Register port
  input  wire pfb_pkg::pfb_bus_t bus,
  output var  logic [15:0]    rdata,
  // PWM levels and blanking signal
  input  wire pfb_pkg::pfb_pwm_t pwm,
  // Raw protection inputs
  input  wire pfb_pkg::pfb_flt_t flt_in,
  // Blanked protection inputs
  output var  pfb_pkg::pfb_flt_t flt_out,
  // Blanking active
  output var  logic           blank_active
);
  import pfb_pkg::*;

  logic [15:0] ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] cnt_reg;
  logic        hi_prev_reg;
  logic        lo_prev_reg;
  logic        trig;
  logic        state_blank;
  logic        leb_act;
  logic        fmask;
  logic        cmask;
  logic [15:0] rd_next;
  logic        hi_out_rise_trig_en;
  logic        hi_out_fall_trig_en;
  logic        lo_out_rise_trig_en;
  logic        lo_out_fall_trig_en;
  logic        fault_edge_blank_en;
  logic        curlim_edge_blank_en;
  logic        ext_sig_high_blank_en;
  logic        ext_sig_low_blank_en;
  logic        hi_out_high_blank_en;
  logic        hi_out_low_blank_en;
  logic        lo_out_high_blank_en;
  logic        lo_out_low_blank_en;

  function automatic logic edge_trig(input logic prev, input logic cur,
                                     input logic rise_en,
                                     input logic fall_en);
    edge_trig = (rise_en & ~prev & cur) | (fall_en & prev & ~cur);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg  <= `PFB_CTRL_RESET;
      count_reg <= `PFB_COUNT_RESET;
    end
    else if (ce && bus.wr)
    begin
      if (bus.addr == `PFB_OFS_CTRL)
        ctrl_reg <= bus.wdata & `PFB_CTRL_MASK;
      else if (bus.addr == `PFB_OFS_COUNT)
        count_reg <= bus.wdata;
    end
  end

  always_comb
  begin
    rd_next = 16'h0000;
    unique case (bus.addr)
      `PFB_OFS_CTRL:   rd_next = ctrl_reg;
      `PFB_OFS_COUNT:  rd_next = count_reg;
      `PFB_OFS_STATUS: rd_next = cnt_reg;
      default:         rd_next = 16'h0000;
    endcase
  end

  // Read data stands one cycle only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 16'h0000;
    else if (ce)
      rdata <= bus.rd ? rd_next : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields by name
  assign hi_out_rise_trig_en   = ctrl_reg[`PFB_BIT_HRISE];
  assign hi_out_fall_trig_en   = ctrl_reg[`PFB_BIT_HFALL];
  assign lo_out_rise_trig_en   = ctrl_reg[`PFB_BIT_LRISE];
  assign lo_out_fall_trig_en   = ctrl_reg[`PFB_BIT_LFALL];
  assign fault_edge_blank_en   = ctrl_reg[`PFB_BIT_FLTLE];
  assign curlim_edge_blank_en  = ctrl_reg[`PFB_BIT_CLLE];
  assign ext_sig_high_blank_en = ctrl_reg[`PFB_BIT_SIGH];
  assign ext_sig_low_blank_en  = ctrl_reg[`PFB_BIT_SIGL];
  assign hi_out_high_blank_en  = ctrl_reg[`PFB_BIT_HH];
  assign hi_out_low_blank_en   = ctrl_reg[`PFB_BIT_HL];
  assign lo_out_high_blank_en  = ctrl_reg[`PFB_BIT_LH];
  assign lo_out_low_blank_en   = ctrl_reg[`PFB_BIT_LL];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hi_prev_reg <= 1'b0;
      lo_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      hi_prev_reg <= pwm.high_side_output;
      lo_prev_reg <= pwm.low_side_output;
    end
  end

  assign trig =
    edge_trig(hi_prev_reg, pwm.high_side_output,
              hi_out_rise_trig_en, hi_out_fall_trig_en) |
    edge_trig(lo_prev_reg, pwm.low_side_output,
              lo_out_rise_trig_en, lo_out_fall_trig_en);

  ////////////////////////////////////////////////////////////////////////////
  // interval counter, restart on edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_reg <= `PFB_CNT_ZERO;
    else if (ce)
    begin
      if (trig)
        cnt_reg <= count_reg;
      else if (cnt_reg != `PFB_CNT_ZERO)
        cnt_reg <= cnt_reg - `PFB_CNT_ONE;
    end
  end

  assign leb_act = (cnt_reg != `PFB_CNT_ZERO);

  assign state_blank =
    (ext_sig_high_blank_en &  pwm.blank_sig) |
    (ext_sig_low_blank_en  & ~pwm.blank_sig) |
    (hi_out_high_blank_en  &  pwm.high_side_output) |
    (hi_out_low_blank_en   & ~pwm.high_side_output) |
    (lo_out_high_blank_en  &  pwm.low_side_output) |
    (lo_out_low_blank_en   & ~pwm.low_side_output);

  assign fmask = (fault_edge_blank_en & leb_act) | state_blank;
  assign cmask = (curlim_edge_blank_en & leb_act) | state_blank;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs, one cycle after inputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flt_out      <= '0;
      blank_active <= 1'b0;
    end
    else if (ce)
    begin
      flt_out.fault  <= flt_in.fault & ~fmask;
      flt_out.curlim <= flt_in.curlim & ~cmask;
      blank_active   <= leb_act | state_blank;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_trig_load;
    @(posedge clk) disable iff (!resetn)
    (ce && trig) |=> (cnt_reg == $past(count_reg));
  endproperty
  a_trig_load: assert property (p_trig_load)
    else $error("counter not loaded on edge");

  property p_hrise;
    @(posedge clk) disable iff (!resetn)
    (ce && ctrl_reg[`PFB_BIT_HRISE] && !hi_prev_reg
     && pwm.high_side_output) |-> trig;
  endproperty
  a_hrise: assert property (p_hrise)
    else $error("high rise missed");

  property p_hfall;
    @(posedge clk) disable iff (!resetn)
    (ce && ctrl_reg[`PFB_BIT_HFALL] && hi_prev_reg
     && !pwm.high_side_output) |-> trig;
  endproperty
  a_hfall: assert property (p_hfall)
    else $error("high fall missed");

  property p_lrise;
    @(posedge clk) disable iff (!resetn)
    (ce && ctrl_reg[`PFB_BIT_LRISE] && !lo_prev_reg
     && pwm.low_side_output) |-> trig;
  endproperty
  a_lrise: assert property (p_lrise)
    else $error("low rise missed");

  property p_lfall;
    @(posedge clk) disable iff (!resetn)
    (ce && ctrl_reg[`PFB_BIT_LFALL] && lo_prev_reg
     && !pwm.low_side_output) |-> trig;
  endproperty
  a_lfall: assert property (p_lfall)
    else $error("low fall missed");

  property p_no_trig;
    @(posedge clk) disable iff (!resetn)
    !(hi_out_rise_trig_en || hi_out_fall_trig_en ||
      lo_out_rise_trig_en || lo_out_fall_trig_en) |-> !trig;
  endproperty
  a_no_trig: assert property (p_no_trig)
    else $error("trigger with enables clear");

  property p_fault_mask;
    @(posedge clk) disable iff (!resetn)
    (ce && ctrl_reg[`PFB_BIT_FLTLE] && leb_act && flt_in.fault)
      |=> !flt_out.fault;
  endproperty
  a_fault_mask: assert property (p_fault_mask)
    else $error("fault passed in edge blanking");

  property p_cl_pass;
    @(posedge clk) disable iff (!resetn)
    (ce && !ctrl_reg[`PFB_BIT_CLLE] && !state_blank && flt_in.curlim)
      |=> flt_out.curlim;
  endproperty
  a_cl_pass: assert property (p_cl_pass)
    else $error("current limit masked wrongly");

  property p_state;
    @(posedge clk) disable iff (!resetn)
    (ce && state_blank) |=> (!flt_out.fault && !flt_out.curlim);
  endproperty
  a_state: assert property (p_state)
    else $error("state blanking leak");

  sequence s_hh;
    ctrl_reg[`PFB_BIT_HH] && pwm.high_side_output;
  endsequence
  property p_hh;
    @(posedge clk) disable iff (!resetn)
    s_hh |-> state_blank;
  endproperty
  a_hh: assert property (p_hh)
    else $error("high-high blank missing");

  property p_count_down;
    @(posedge clk) disable iff (!resetn)
    (ce && !trig && leb_act) |=> (cnt_reg == $past(cnt_reg) - 16'h0001);
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("counter not decrementing");

  property p_cl_mask;
    @(posedge clk) disable iff (!resetn)
    (ce && curlim_edge_blank_en && leb_act) |=> !flt_out.curlim;
  endproperty
  a_cl_mask: assert property (p_cl_mask)
    else $error("current limit passed in edge blanking");

  property p_sig_hi;
    @(posedge clk) disable iff (!resetn)
    (ext_sig_high_blank_en && pwm.blank_sig) |-> state_blank;
  endproperty
  a_sig_hi: assert property (p_sig_hi)
    else $error("signal-high blank missing");

  property p_sig_lo;
    @(posedge clk) disable iff (!resetn)
    (ext_sig_low_blank_en && !pwm.blank_sig) |-> state_blank;
  endproperty
  a_sig_lo: assert property (p_sig_lo)
    else $error("signal-low blank missing");

  property p_hl;
    @(posedge clk) disable iff (!resetn)
    (hi_out_low_blank_en && !pwm.high_side_output) |-> state_blank;
  endproperty
  a_hl: assert property (p_hl)
    else $error("high-low blank missing");

  property p_lh;
    @(posedge clk) disable iff (!resetn)
    (lo_out_high_blank_en && pwm.low_side_output) |-> state_blank;
  endproperty
  a_lh: assert property (p_lh)
    else $error("low-high blank missing");

  property p_ll;
    @(posedge clk) disable iff (!resetn)
    (lo_out_low_blank_en && !pwm.low_side_output) |-> state_blank;
  endproperty
  a_ll: assert property (p_ll)
    else $error("low-low blank missing");

  // No enabled condition, no state blanking
  property p_state_off;
    @(posedge clk) disable iff (!resetn)
    !(ext_sig_high_blank_en || ext_sig_low_blank_en ||
      hi_out_high_blank_en || hi_out_low_blank_en ||
      lo_out_high_blank_en || lo_out_low_blank_en) |-> !state_blank;
  endproperty
  a_state_off: assert property (p_state_off)
    else $error("state blanking with enables clear");

  // Masking only ever removes a trip, never adds one
  property p_fault_quiet;
    @(posedge clk) disable iff (!resetn)
    (ce && !flt_in.fault) |=> !flt_out.fault;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet)
    else $error("fault output without input");

  property p_ce_hold;
    @(posedge clk) disable iff (!resetn)
    !ce |=> ($stable(cnt_reg) && $stable(ctrl_reg) && $stable(rdata));
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("state moved with enable low");

endmodule // pfb_blank

`default_nettype wire

// ### verification/pfb_pwm_model.sv
// Behavioural PWM output stage and comparators facing the blanking block
`timescale 1ns/1ps
`default_nettype none

module pfb_pwm_model
(
  // Clock
  input  wire logic              clk,
  // Levels into the block
  output var  pfb_pkg::pfb_pwm_t pwm,
  output var  pfb_pkg::pfb_flt_t flt
);
  import pfb_pkg::*;

  // Comparators start tripped so any gap in masking shows
  initial
  begin
    pwm = '0;
    flt = 2'h3;
  end

  // Levels move only at an edge, like a registered output stage
  task automatic step(input logic h, input logic l, input logic s);
    @(posedge clk);
    pwm <= pfb_pwm_t'{h, l, s};
  endtask

  // Comparator levels, also moved only at an edge
  task automatic trip(input logic f, input logic c);
    @(posedge clk);
    flt <= pfb_flt_t'{f, c};
  endtask
endmodule // pfb_pwm_model

`default_nettype wire

// ### verification/tb_pfb_blank.sv
// Self-checking bench for the fault blanking block
`timescale 1ns/1ps
`default_nettype none

module tb_pfb_blank;
  import pfb_pkg::*;

  logic        clk;
  logic        resetn;
  pfb_bus_t    bus;
  logic [15:0] rdata;
  pfb_pwm_t    pwm;
  pfb_flt_t    flt_in;
  pfb_flt_t    flt_out;
  logic        blank_active;
  logic        ce;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          nf;
  int          nc;
  logic [15:0] d;

  ////////////////////////////////////////////////////////////////////
  pfb_pwm_model pfb_pwm_model_i (.clk(clk), .pwm(pwm), .flt(flt_in));

  pfb_blank pfb_blank_i
  (
    .clk(clk), .resetn(resetn), .ce(ce), .bus(bus), .rdata(rdata),
    .pwm(pwm), .flt_in(flt_in), .flt_out(flt_out),
    .blank_active(blank_active)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Masked cycles, sampled mid-cycle away from the edge
  always @(negedge clk)
  begin
    if (flt_out.fault !== 1'b1)
      nf++;
    if (flt_out.curlim !== 1'b1)
      nc++;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    bus <= pfb_bus_t'{1'b1, 1'b0, a, v};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    bus <= pfb_bus_t'{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask

  task automatic lvl(input int i, input logic v);
    pfb_pwm_model_i.step(i < 2 ? v : 1'b0, i < 2 ? 1'b0 : v, 1'b0);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(4'h1, d);
    check(d, 16'h000A);
    rd(4'h0, d);
    check(d, 16'h0000);
    wr(4'h0, 16'hFFFF);
    rd(4'h0, d);
    check(d, 16'hFC3F);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, d);
    check(d, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0003);
    $display("test registers done");
  endtask

  // Each edge kind alone, first with only the others enabled, then enabled
  task automatic t_edges();
    logic [15:0] c;
    logic        b;
    for (int i = 0; i < 4; i++)
      for (int en = 0; en < 2; en++)
      begin
        b = i[0];
        wr(4'h0, 16'h0000);
        lvl(i, b);
        repeat (4) @(posedge clk);
        c = 16'h8000 >> i;
        c = en ? c | (i[0] ? 16'h0400 : 16'h0800) : c ^ 16'hFC00;
        wr(4'h0, c);
        nf = 0;
        nc = 0;
        lvl(i, !b);
        repeat (8) @(posedge clk);
        check(16'(nf), (en && !i[0]) ? 16'h0003 : 16'h0000);
        check(16'(nc), (en && i[0]) ? 16'h0003 : 16'h0000);
      end
    $display("test edges done");
  endtask

  task automatic t_restart();
    wr(4'h0, 16'h8800);
    nf = 0;
    pfb_pwm_model_i.step(1'b1, 1'b0, 1'b0);
    pfb_pwm_model_i.step(1'b0, 1'b0, 1'b0);
    pfb_pwm_model_i.step(1'b1, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    check(16'(nf), 16'h0005);
    $display("test restart done");
  endtask

  // Each state condition alone, false then true
  task automatic t_state();
    logic v;
    for (int n = 0; n < 6; n++)
    begin
      wr(4'h0, 16'h0001 << n);
      for (int t = 0; t < 2; t++)
      begin
        v = t ? n[0] : !n[0];
        pfb_pwm_model_i.step(n / 2 == 1 ? v : 1'b0,
                             n / 2 == 0 ? v : 1'b0,
                             n / 2 == 2 ? v : 1'b0);
        @(posedge clk);
        @(negedge clk);
        check({14'h0000, flt_out}, t ? 16'h0000 : 16'h0003);
        check({15'h0000, blank_active}, 16'(t));
        @(posedge clk);
      end
    end
    $display("test state done");
  endtask

  // Low enable freezes the counter and ignores the bus
  task automatic t_freeze();
    wr(4'h0, 16'h8800);
    pfb_pwm_model_i.step(1'b1, 1'b0, 1'b0);
    @(posedge clk);
    ce <= 1'b0;
    wr(4'h0, 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    rd(4'h2, d);
    check(d, 16'h0003);
    rd(4'h0, d);
    check(d, 16'h8800);
    $display("test freeze done");
  endtask

  // Quiet comparators must give quiet outputs
  task automatic t_pass();
    wr(4'h0, 16'h0000);
    pfb_pwm_model_i.trip(1'b0, 1'b1);
    @(posedge clk);
    @(negedge clk);
    check({14'h0000, flt_out}, 16'h0001);
    pfb_pwm_model_i.trip(1'b1, 1'b0);
    @(posedge clk);
    @(negedge clk);
    check({14'h0000, flt_out}, 16'h0002);
    pfb_pwm_model_i.trip(1'b1, 1'b1);
    $display("test pass done");
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    bus = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_edges();
    t_restart();
    t_state();
    t_freeze();
    t_pass();
    conclude();
  end
endmodule // tb_pfb_blank

`default_nettype wire
